/* hdl/bps_pkg.sv */
// Constants for the primary status, class code and line size register bank.
package bps_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          NUM_EVT       = 6;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_CLASS     = 8'h08;
    localparam logic [7:0]  OFS_LINE      = 8'h0c;
    // Status bit positions inside the 32-bit word at OFS_STATUS; bits 31 to 27 and 24 are sticky.
    localparam int          BIT_PAR_DET   = 31;
    localparam int          BIT_SERR      = 30;
    localparam int          BIT_MST_ABT   = 29;
    localparam int          BIT_TGT_ABT_R = 28;
    localparam int          BIT_TGT_ABT_S = 27;
    localparam int          BIT_DATA_PAR  = 24;
    localparam int          BIT_B2B       = 23;
    localparam int          BIT_66MHZ     = 21;
    localparam int          BIT_CAP_LIST  = 20;
    localparam logic [1:0]  DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0]  BASE_CLASS    = 8'h06;
    localparam logic [7:0]  SUB_CLASS     = 8'h04;
    localparam logic [7:0]  PROG_IF       = 8'h00;
    localparam logic [7:0]  LINE_RESET    = 8'h00;
    localparam logic [7:0]  LINE_LEGAL    = 8'h3c;
    localparam logic [5:0]  STS_RESET     = 6'h00;
    localparam int          STRB_STATUS   = 3;
    localparam int          STRB_LINE     = 0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : bps_pkg

/* hdl/bps_regs.sv */
// Primary status, revision, class code and line size registers behind AXI4-Lite.
//
// Overview of operation
// - Sticky status bits read their value, clear on written one, hold on zero.
// - Bit 31 sets on a primary address or data parity error; reset zero.
// - Bit 30 sets when the bridge drives system error; reset zero.
// - Bit 29 sets on a received master abort; reset zero.
// - Bit 28 sets on a received target abort; reset zero.
// - Bit 27 sets when the bridge signals a target abort.
// - Bits 26 to 25 always read 01, medium decode timing.
// - Bit 24 sets on a data parity error; reset zero.
// - Bit 23 reads 0 in PCI-X mode and 1 in conventional mode.
// - Bit 21 always reads 1, 66 MHz capable.
// - Bit 20 is the capability list flag; reads 0 by default.
// - Bits 22 and 19 to 16 read zero; writes ignored.
// - Bits 7 to 0 at the class word return a fixed revision code.
// - Base class field reads 06h.
// - Sub-class field reads 04h.
// - Programming interface field reads zero.
// - Line size register is read-write; used only in conventional mode.
// - Line size is one-hot: bits 5,4,3,2 give 32,16,8,4 doublewords.
`timescale 1ns/100ps
module bps_regs
    import bps_pkg::*;
#(
    // Arbitrary revision value, not tied to any real part.
    parameter logic [7:0] REVISION = 8'h3c,
    parameter bit         CAP_LIST = 1'b0
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              pcix_mode,
    input  wire logic              parity_err_det,
    input  wire logic              serr_driven,
    input  wire logic              master_abort_rcvd,
    input  wire logic              target_abort_rcvd,
    input  wire logic              target_abort_sent,
    input  wire logic              data_parity_err,
    output logic                   line_size_use,
    output logic [7:0]             line_dwords
);

    logic [ADDR_W-1:0] aw_addr;
    logic              aw_hold;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              w_hold;
    logic [NUM_EVT-1:0] sts;
    logic [7:0]        line_size;

    wire               aw_take  = s_axi_awvalid & s_axi_awready;
    wire               w_take   = s_axi_wvalid & s_axi_wready;
    wire               ar_take  = s_axi_arvalid & s_axi_arready;
    wire               do_write = aw_hold & w_hold & ~s_axi_bvalid;
    wire               next_aw_hold = (aw_hold | aw_take) & ~do_write;
    wire               next_w_hold  = (w_hold | w_take) & ~do_write;
    wire               next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    wire [7:0]         wr_ofs = {aw_addr[ADDR_W-1:2], 2'b00};
    wire [7:0]         rd_ofs = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire               wr_status = wr_ofs == OFS_STATUS;
    wire               wr_class  = wr_ofs == OFS_CLASS;
    wire               wr_line   = wr_ofs == OFS_LINE;
    wire               wr_hit    = wr_status | wr_class | wr_line;
    wire               rd_status = rd_ofs == OFS_STATUS;
    wire               rd_class  = rd_ofs == OFS_CLASS;
    wire               rd_line   = rd_ofs == OFS_LINE;
    wire               rd_hit    = rd_status | rd_class | rd_line;

    // Event inputs in the order of their status bit positions.
    wire [NUM_EVT-1:0] evt = {parity_err_det, serr_driven, master_abort_rcvd,
                              target_abort_rcvd, target_abort_sent, data_parity_err};
    // Only byte lane three carries sticky bits; the other lanes ignore writes.
    wire               clr_en = do_write & wr_status & w_strb[STRB_STATUS];
    wire [NUM_EVT-1:0] clr_mask = {w_data[BIT_PAR_DET], w_data[BIT_SERR],
                                   w_data[BIT_MST_ABT], w_data[BIT_TGT_ABT_R],
                                   w_data[BIT_TGT_ABT_S], w_data[BIT_DATA_PAR]};
    wire [NUM_EVT-1:0] next_sts;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++)
        begin : g_sticky
            // An event outranks a clear so that nothing is lost in that cycle.
            assign next_sts[gi] = evt[gi] | (sts[gi] & ~(clr_en & clr_mask[gi]));
        end
    endgenerate

    // Read word of the status register; the low command half is held elsewhere.
    wire [DATA_W-1:0] status_word;
    assign status_word = {sts[5], sts[4], sts[3], sts[2], sts[1],
                          DEVSEL_MEDIUM,
                          sts[0],
                          ~pcix_mode,
                          1'b0,
                          1'b1,
                          CAP_LIST,
                          4'h0,
                          16'h0000};
    wire [DATA_W-1:0] class_word = {BASE_CLASS, SUB_CLASS, PROG_IF, REVISION};
    wire [DATA_W-1:0] line_word  = {24'h000000, line_size};
    wire [DATA_W-1:0] rd_word = rd_status ? status_word :
                                rd_class  ? class_word  :
                                rd_line   ? line_word   : {DATA_W{1'b0}};

    // A legal line size has exactly one bit set and only in the supported range.
    wire              line_onehot = (line_size & (line_size - 8'h01)) == 8'h00;
    wire              line_legal  = (line_size != 8'h00) & line_onehot &
                                    ((line_size & ~LINE_LEGAL) == 8'h00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            aw_hold       <= next_aw_hold;
            w_hold        <= next_w_hold;
            s_axi_awready <= ~next_aw_hold;
            s_axi_wready  <= ~next_w_hold;
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= ~next_rvalid;
            if (ar_take)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sts <= STS_RESET;
        else
            sts <= next_sts;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            line_size <= LINE_RESET;
        else if (do_write & wr_line & w_strb[STRB_LINE])
            line_size <= w_data[7:0];
    end

    // PCI-X mode ignores the line size, so line_size_use drops then; line_dwords still gives a legal size.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_size_use <= 1'b0;
            line_dwords   <= 8'h00;
        end
        else
        begin
            line_size_use <= line_legal & ~pcix_mode;
            line_dwords   <= line_legal ? line_size : 8'h00;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_clear_wr(int b);
        clr_en && w_data[b];
    endsequence

    sequence s_status_rd;
        ar_take && rd_status;
    endsequence

    property p_rwc_zero_keeps;
        clr_en && !w_data[BIT_SERR] && sts[4] |=> sts[4];
    endproperty
    a_rwc_zero_keeps: assert property (p_rwc_zero_keeps)
        else $error("Sticky bit lost on a zero write.");

    property p_rwc_one_clears;
        s_clear_wr(BIT_MST_ABT) ##0 !master_abort_rcvd |=> !sts[3];
    endproperty
    a_rwc_one_clears: assert property (p_rwc_one_clears)
        else $error("Sticky bit not cleared by a one.");

    property p_parity_sets;
        parity_err_det |=> sts[5];
    endproperty
    a_parity_sets: assert property (p_parity_sets)
        else $error("Parity event did not set its bit.");

    property p_serr_sets;
        serr_driven |=> sts[4];
    endproperty
    a_serr_sets: assert property (p_serr_sets)
        else $error("System error event did not set its bit.");

    property p_aborts_set;
        (master_abort_rcvd || target_abort_rcvd || target_abort_sent) |=>
            (sts[3] || !$past(master_abort_rcvd)) && (sts[2] || !$past(target_abort_rcvd))
            && (sts[1] || !$past(target_abort_sent));
    endproperty
    a_aborts_set: assert property (p_aborts_set)
        else $error("Abort event did not set its bit.");

    property p_set_beats_clear;
        s_clear_wr(BIT_DATA_PAR) ##0 data_parity_err |=> sts[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("Event lost against a clear.");

    property p_status_fixed;
        s_status_rd |=> s_axi_rvalid && s_axi_rdata[26:25] == DEVSEL_MEDIUM
            && s_axi_rdata[BIT_66MHZ] && !s_axi_rdata[22] && s_axi_rdata[19:16] == 4'h0
            && s_axi_rdata[BIT_B2B] == !$past(pcix_mode);
    endproperty
    a_status_fixed: assert property (p_status_fixed)
        else $error("Fixed status field read wrong.");

    property p_class_read;
        ar_take && rd_class |=> s_axi_rdata == {BASE_CLASS, SUB_CLASS, PROG_IF, REVISION};
    endproperty
    a_class_read: assert property (p_class_read)
        else $error("Class word read wrong.");

    property p_line_decode;
        !$stable(line_size) |=> ##1 line_dwords ==
            ($past(line_size, 2) inside {8'h04, 8'h08, 8'h10, 8'h20} ? $past(line_size, 2) : 8'h00);
    endproperty
    a_line_decode: assert property (p_line_decode)
        else $error("Line size decode wrong.");

    property p_line_pcix;
        pcix_mode |=> !line_size_use;
    endproperty
    a_line_pcix: assert property (p_line_pcix)
        else $error("Line size used in PCI-X mode.");

    property p_bresp_holds;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_holds: assert property (p_bresp_holds)
        else $error("Write response dropped early.");

    sequence s_write_go;
        aw_hold && w_hold && !s_axi_bvalid;
    endsequence

    // A read must show the sticky bits as they stood at the address take.
    property p_sticky_read;
        s_status_rd |=> s_axi_rdata[BIT_PAR_DET -: NUM_EVT-1] == $past(sts[NUM_EVT-1:1])
            && s_axi_rdata[BIT_DATA_PAR] == $past(sts[0]);
    endproperty
    a_sticky_read: assert property (p_sticky_read)
        else $error("Sticky bits read wrong.");

    property p_sticky_lane_masked;
        s_write_go ##0 (wr_status && !w_strb[STRB_STATUS])
            |=> sts == ($past(sts) | $past(evt));
    endproperty
    a_sticky_lane_masked: assert property (p_sticky_lane_masked)
        else $error("Sticky bit cleared without its byte lane.");

    property p_cap_list_read;
        s_status_rd |=> s_axi_rdata[BIT_CAP_LIST] == CAP_LIST
            && s_axi_rdata[15:0] == 16'h0000;
    endproperty
    a_cap_list_read: assert property (p_cap_list_read)
        else $error("Capability flag or command half read wrong.");

    property p_line_write;
        s_write_go ##0 (wr_line && w_strb[STRB_LINE]) |=> line_size == $past(w_data[7:0]);
    endproperty
    a_line_write: assert property (p_line_write)
        else $error("Line size write lost.");

    property p_line_lane_masked;
        s_write_go ##0 (wr_line && !w_strb[STRB_LINE]) |=> $stable(line_size);
    endproperty
    a_line_lane_masked: assert property (p_line_lane_masked)
        else $error("Line size changed without its byte lane.");

    property p_write_answer;
        s_write_go |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("Write response missing.");

    property p_write_unmapped;
        s_write_go ##0 !wr_hit |=> s_axi_bresp == RESP_SLVERR;
    endproperty
    a_write_unmapped: assert property (p_write_unmapped)
        else $error("Unmapped write not refused.");

    property p_read_answer;
        ar_take |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("Read data missing.");

    property p_read_unmapped;
        ar_take && !rd_hit |=> s_axi_rresp == RESP_SLVERR
            && s_axi_rdata == {DATA_W{1'b0}};
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("Unmapped read not refused.");

    property p_rdata_holds;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("Read data dropped early.");

endmodule : bps_regs

/* verif/tb_top.sv */
// Self-checking bench for the status, class code and line size register bank.
`timescale 1ns/100ps
module tb_top
    import bps_pkg::*;
;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0]        wstrb = '0;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid, use_o, pcix = 1'b0;
    logic [1:0]        bresp, rresp, resp;
    logic [5:0]        evt = '0;
    logic [7:0]        dw;
    logic [31:0]       rd, base;
    int                n_errors = 0;
    int                total_checks = 0;
    int                pos [6] = '{BIT_PAR_DET, BIT_SERR, BIT_MST_ABT, BIT_TGT_ABT_R,
                                   BIT_TGT_ABT_S, BIT_DATA_PAR};
    logic [7:0]        lv [9] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h0c, 8'h40, 8'h01, 8'h24};
    logic [7:0]        ld [9] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #4 aclk = ~aclk;

    bps_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pcix_mode(pcix),
        .parity_err_det(evt[0]), .serr_driven(evt[1]), .master_abort_rcvd(evt[2]),
        .target_abort_rcvd(evt[3]), .target_abort_sent(evt[4]), .data_parity_err(evt[5]),
        .line_size_use(use_o), .line_dwords(dw));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Address and data are offered together and each released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                done = 1;
            end
        end
        bready <= 1'b0;
        if (!done) check(0, 1, "write response missing");
    endtask

    task automatic rdw(input logic [7:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                rd = rdata;
                resp = rresp;
                done = 1;
            end
        end
        rready <= 1'b0;
        if (!done) check(0, 1, "read data missing");
    endtask

    task automatic pulse(input logic [5:0] m);
        @(posedge aclk);
        evt <= m;
        @(posedge aclk);
        evt <= '0;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end

    initial
    begin
        // Fixed fields of the status word in conventional mode, command half reads zero.
        base = (32'(DEVSEL_MEDIUM) << 25) | (32'h1 << BIT_66MHZ) | (32'h1 << BIT_B2B);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdw(OFS_STATUS);
        check(rd, base, "status reset");
        rdw(OFS_CLASS);
        check(rd, 32'h0604003c, "class word");
        rdw(OFS_LINE);
        check(rd, 32'h0, "line reset");
        $display("Reset values done");
        for (int k = 0; k < 6; k++)
        begin
            pulse(6'h1 << k);
            rdw(OFS_STATUS);
            check(rd, base | (32'h1 << pos[k]), "event sets bit");
            wr(OFS_STATUS, 32'h0, 4'hf);
            wr(OFS_STATUS, 32'hffffffff, 4'h7);
            rdw(OFS_STATUS);
            check(rd, base | (32'h1 << pos[k]), "zero or masked write holds");
            wr(OFS_STATUS, 32'h1 << pos[k], 4'h8);
            rdw(OFS_STATUS);
            check(rd, base, "write one clears");
        end
        @(posedge aclk);
        evt <= 6'h3f;
        wr(OFS_STATUS, 32'hffffffff, 4'hf);
        @(posedge aclk);
        evt <= '0;
        rdw(OFS_STATUS);
        check(rd, base | 32'hf9000000, "set beats clear");
        wr(OFS_STATUS, 32'hffffffff, 4'hf);
        rdw(OFS_STATUS);
        check(rd, base, "all cleared, reserved still zero");
        $display("Sticky status done");
        for (int k = 0; k < 9; k++)
        begin
            wr(OFS_LINE, {24'hffffff, lv[k]}, 4'h1);
            rdw(OFS_LINE);
            check(rd, {24'h0, lv[k]}, "line readback");
            check(dw, ld[k], "line dwords");
            check(use_o, ld[k] != 0, "line use");
        end
        wr(OFS_LINE, 32'h0, 4'he);
        rdw(OFS_LINE);
        check(rd, 32'h24, "line strobe masked");
        wr(OFS_LINE, 32'h08, 4'h1);
        @(posedge aclk);
        check(use_o, 1'b1, "line used in conventional mode");
        pcix <= 1'b1;
        repeat (3) @(posedge aclk);
        check(use_o, 1'b0, "line unused in fast mode");
        rdw(OFS_STATUS);
        check(rd, base & ~(32'h1 << BIT_B2B), "b2b bit in fast mode");
        $display("Line size done");
        wr(OFS_CLASS, 32'hffffffff, 4'hf);
        check(resp, RESP_OKAY, "class write okay");
        rdw(OFS_CLASS);
        check(rd, 32'h0604003c, "class unchanged");
        for (int k = 0; k < 2; k++)
        begin
            wr(8'(8'h10 * k), 32'hffffffff, 4'hf);
            check(resp, RESP_SLVERR, "unmapped write");
            rdw(8'(8'h10 * k));
            check(resp, RESP_SLVERR, "unmapped read");
            check(rd, 32'h0, "unmapped data");
        end
        $display("Decode done");
        final_report();
    end
endmodule // tb_top
